// ---- acq_device.sv ----
module acq_device #(
  parameter int DEPTH = 64
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  acq_link_if.device                         link,
  output logic                               frameStrobe,
  output logic [acq_pkg::SEL_W-1:0]          chanSel,
  input  wire logic [acq_pkg::SAMPLE_W-1:0]  chanData,
  input  wire logic                          externalAcquireGate,
  input  wire logic                          fpTurnPin,
  output logic [acq_pkg::WORD_W-1:0]         fpData,
  output logic                               fpValid,
  output logic                               fpOe
);
  localparam int AW = $clog2(DEPTH);

  logic                          gateMeta;
  logic                          gateSync;
  logic                          gatePrev;
  logic                          turnMeta;
  logic                          turnSync;
  logic [1:0]                    quarterCnt;
  logic [7:0]                    modCnt;
  logic [7:0]                    modPerFrame;
  logic                          modEdge;
  logic                          frameEdge;
  logic                          extArmed;
  logic                          request;
  logic                          active;
  logic [acq_pkg::DEC_W-1:0]     decCnt;
  logic [acq_pkg::DEC_W-1:0]     decimN;
  logic [acq_pkg::CH_W-1:0]      numCh;
  logic                          roomOk;
  logic                          start;
  acq_pkg::gather_t              state;
  logic [acq_pkg::SAMPLE_W-1:0]  mem [2][DEPTH];
  logic [AW:0]                   wrPtr [2];
  logic [AW:0]                   rdPtr [2];
  logic [1:0]                    push;
  logic [1:0]                    pop;
  logic [1:0]                    nonEmpty;
  logic [acq_pkg::SAMPLE_W-1:0]  head [2];
  logic                          outValid;
  logic [acq_pkg::WORD_W-1:0]    outData;
  acq_pkg::outsel_t              outSel;
  logic                          load;
  logic                          next_outValid;
  logic [acq_pkg::WORD_W-1:0]    next_outData;
  acq_pkg::outsel_t              next_outSel;

  function automatic logic [AW:0] fill(input logic [AW:0] w, input logic [AW:0] r);
    return w - r;
  endfunction : fill

  always_ff @(posedge clk)
  begin
    gateMeta <= externalAcquireGate;
    gateSync <= gateMeta;
    gatePrev <= gateSync;
    turnMeta <= fpTurnPin;
    turnSync <= turnMeta;
  end

  // frame timing assumes sampleTick at 256x / 512x output rate
  assign modPerFrame = link.ratio128 ? acq_pkg::MOD_PER_FRAME_128 : acq_pkg::MOD_PER_FRAME_64;
  assign modEdge = link.sampleTick && (quarterCnt == 2'(acq_pkg::TICKS_PER_MOD - 1));
  // a count left past the end by a ratio change still closes the frame
  assign frameEdge = modEdge && (modCnt >= modPerFrame - 8'h01);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      quarterCnt <= 2'h0;
    else if (link.sampleTick)
      quarterCnt <= quarterCnt + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      modCnt <= 8'h00;
    else if (frameEdge)
      modCnt <= 8'h00;
    else if (modEdge)
      modCnt <= modCnt + 8'h01;
  end

  // a rise is needed to arm, but a rise seen before extSource selects the gate still starts
  always_ff @(posedge clk)
  begin
    if (!rstn)
      extArmed <= 1'b0;
    else if (gateSync && !gatePrev)
      extArmed <= 1'b1;
    else if (!gateSync)
      extArmed <= 1'b0;
  end

  assign request = link.extSource ? extArmed : link.swAcquire;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      active <= 1'b0;
    else if (frameEdge)
      active <= request;
  end

  assign decimN = acq_pkg::decimFactor(acq_pkg::WORD_W'(link.decim));

  always_ff @(posedge clk)
  begin
    if (!rstn)
      decCnt <= '0;
    else if (frameEdge)
    begin
      if (!request)
        decCnt <= '0;
      else if (decCnt >= decimN - acq_pkg::DEC_W'(1))
        decCnt <= '0;
      else
        decCnt <= decCnt + acq_pkg::DEC_W'(1);
    end
  end

  assign numCh = acq_pkg::evenChannels(acq_pkg::WORD_W'(link.numChan));
  // whole frame or nothing: a frame without room in both FIFOs is dropped
  assign roomOk = (int'(fill(wrPtr[0], rdPtr[0])) + int'(numCh >> 1) <= DEPTH)
               && (int'(fill(wrPtr[1], rdPtr[1])) + int'(numCh >> 1) <= DEPTH);
  assign start = frameEdge && request && (decCnt == '0) && (state == acq_pkg::G_IDLE)
              && (numCh != '0) && roomOk;

  always_ff @(posedge clk)
  begin
    if (!rstn || link.fifoReset)
    begin
      state       <= acq_pkg::G_IDLE;
      chanSel     <= '0;
      frameStrobe <= 1'b0;
    end
    else
    begin
      frameStrobe <= 1'b0;
      case (state)
        acq_pkg::G_IDLE:
        begin
          if (start)
          begin
            state       <= acq_pkg::G_LATCH;
            frameStrobe <= 1'b1; // one instant for every channel
            chanSel     <= '0; // channel one first
          end
        end
        acq_pkg::G_LATCH:
          state <= acq_pkg::G_READ;
        acq_pkg::G_READ:
        begin
          if (acq_pkg::CH_W'(chanSel) == numCh - acq_pkg::CH_W'(1))
            state <= acq_pkg::G_IDLE;
          else
            chanSel <= chanSel + acq_pkg::SEL_W'(1);
        end
        default:
          state <= acq_pkg::G_IDLE;
      endcase
    end
  end

  // channel one (index 0) is odd
  assign push[0] = (state == acq_pkg::G_READ) && !chanSel[0];
  assign push[1] = (state == acq_pkg::G_READ) && chanSel[0];

  always_ff @(posedge clk)
  begin
    for (int b = 0; b < 2; b++)
    begin
      if (push[b])
        mem[b][wrPtr[b][AW-1:0]] <= chanData;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int b = 0; b < 2; b++)
    begin
      if (!rstn || link.fifoReset)
      begin
        wrPtr[b] <= '0;
        rdPtr[b] <= '0;
      end
      else
      begin
        if (push[b])
          wrPtr[b] <= wrPtr[b] + (AW+1)'(1);
        if (pop[b])
          rdPtr[b] <= rdPtr[b] + (AW+1)'(1);
      end
    end
  end

  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      nonEmpty[b] = (wrPtr[b] != rdPtr[b]);
      head[b]     = mem[b][rdPtr[b][AW-1:0]];
    end
  end

  assign load = !outValid || link.wordReady;

  always_comb
  begin
    next_outValid = outValid && !link.wordReady;
    next_outData  = outData;
    next_outSel   = outSel;
    pop           = 2'b00;
    if (load)
    begin
      if (link.packWords)
      begin
        if (nonEmpty[0] && nonEmpty[1])
        begin
          next_outData  = {head[0][acq_pkg::SAMPLE_W-1 -: acq_pkg::HALF_W],
                           head[1][acq_pkg::SAMPLE_W-1 -: acq_pkg::HALF_W]};
          next_outValid = 1'b1;
          pop           = 2'b11;
        end
      end
      else if (nonEmpty[outSel])
      begin
        next_outData  = {head[outSel], {acq_pkg::PAD_W{1'b0}}};
        next_outValid = 1'b1;
        pop[outSel]   = 1'b1;
        next_outSel   = (outSel == acq_pkg::O_ODD) ? acq_pkg::O_EVEN : acq_pkg::O_ODD;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || link.fifoReset)
    begin
      outValid <= 1'b0;
      outData  <= '0;
      outSel   <= acq_pkg::O_ODD;
    end
    else
    begin
      outValid <= next_outValid;
      outData  <= next_outData;
      outSel   <= next_outSel;
    end
  end

  assign link.wordValid = outValid;
  assign link.wordData  = outData;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      link.acqActive <= 1'b0;
      link.halfFull  <= 1'b0;
      link.fifoEmpty <= 1'b1;
    end
    else
    begin
      link.acqActive <= active;
      link.halfFull  <= int'(fill(wrPtr[0], rdPtr[0])) >= DEPTH / 2;
      link.fifoEmpty <= !nonEmpty[0] && !nonEmpty[1];
    end
  end

  // front panel always carries full format; words missed outside our turn
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fpData  <= '0;
      fpValid <= 1'b0;
      fpOe    <= 1'b0;
    end
    else
    begin
      fpOe    <= turnSync;
      fpValid <= (state == acq_pkg::G_READ) && turnSync;
      if (state == acq_pkg::G_READ)
        fpData <= {chanData, {acq_pkg::PAD_W{1'b0}}};
    end
  end
endmodule : acq_device

// ---- acq_host.sv ----
module acq_host (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [acq_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [acq_pkg::WORD_W-1:0]  pwdata,
  output logic [acq_pkg::WORD_W-1:0]       prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        extClockPin,
  output logic                             sampleClkOut,
  output logic                             clusterTrigger,
  acq_link_if.host                         link
);
  logic [acq_pkg::CTRL_W-1:0]   ctrl;
  logic [acq_pkg::CH_W-1:0]     numChan;
  logic [acq_pkg::DEC_W-1:0]    decim;
  logic [acq_pkg::WORD_W-1:0]   clkWord;
  logic [acq_pkg::WORD_W-1:0]   acc;
  logic                         carry;
  logic                         clkMeta;
  logic                         clkSync;
  logic                         clkPrev;
  logic                         fifoReset;
  logic                         wrAcc;
  logic                         rdAcc;
  logic                         mapped;
  logic [acq_pkg::WORD_W-1:0]   bufMem [2];
  logic                         bufWr;
  logic                         bufRd;
  logic [1:0]                   bufCnt;
  logic                         bufPush;
  logic                         bufPop;
  logic                         popArmed;

  assign mapped = (paddr == acq_pkg::CTRL_OFS) || (paddr == acq_pkg::NUMCH_OFS)
               || (paddr == acq_pkg::DECIM_OFS) || (paddr == acq_pkg::CLKWD_OFS)
               || (paddr == acq_pkg::STATUS_OFS) || (paddr == acq_pkg::DATA_OFS);
  assign wrAcc   = psel && penable && pwrite && mapped;
  assign rdAcc   = psel && penable && !pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl    <= acq_pkg::CTRL_RESET;
      numChan <= acq_pkg::NUMCH_RESET;
      decim   <= acq_pkg::DECIM_RESET;
      clkWord <= acq_pkg::CLKWD_RESET;
    end
    else if (wrAcc)
    begin
      case (paddr)
        acq_pkg::CTRL_OFS:  ctrl    <= pwdata[acq_pkg::CTRL_W-1:0];
        acq_pkg::NUMCH_OFS: numChan <= acq_pkg::evenChannels(pwdata);
        acq_pkg::DECIM_OFS: decim   <= acq_pkg::decimFactor(pwdata);
        acq_pkg::CLKWD_OFS: clkWord <= pwdata;
        default:            ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      fifoReset <= 1'b0;
    else
      fifoReset <= wrAcc && (paddr == acq_pkg::CTRL_OFS) && pwdata[acq_pkg::CTRL_FRST];
  end

  // phase accumulator: tick rate = 40 MHz * word / 2^32, far finer than 20 Hz
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      acc   <= '0;
      carry <= 1'b0;
    end
    else
      {carry, acc} <= {1'b0, acc} + {1'b0, clkWord};
  end

  always_ff @(posedge clk)
  begin
    clkMeta <= extClockPin;
    clkSync <= clkMeta;
    clkPrev <= clkSync;
  end

  // each edge of the external clock is one tick, so a toggle carries one tick per edge
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sampleClkOut    <= 1'b0;
      link.sampleTick <= 1'b0;
    end
    else
    begin
      if (carry && ctrl[acq_pkg::CTRL_MASTER])
        sampleClkOut <= !sampleClkOut;
      link.sampleTick <= ctrl[acq_pkg::CTRL_EXTCLK] ? (clkSync ^ clkPrev) : carry;
    end
  end

  assign clusterTrigger = ctrl[acq_pkg::CTRL_MASTER] && ctrl[acq_pkg::CTRL_ACQ];

  assign link.swAcquire = ctrl[acq_pkg::CTRL_ACQ];
  assign link.extSource = ctrl[acq_pkg::CTRL_EXTSRC];
  assign link.packWords = ctrl[acq_pkg::CTRL_PACK];
  assign link.ratio128  = ctrl[acq_pkg::CTRL_RATIO];
  assign link.fifoReset = fifoReset;
  assign link.numChan   = numChan;
  assign link.decim     = decim;

  // two entries: a stalled reader holds back the device without losing a word
  assign link.wordReady = (bufCnt != 2'h2);
  assign bufPush = link.wordValid && link.wordReady;
  assign bufPop  = rdAcc && (paddr == acq_pkg::DATA_OFS) && popArmed && (bufCnt != 2'h0);

  // pop only a word that the setup cycle already latched into prdata
  always_ff @(posedge clk)
  begin
    if (!rstn)
      popArmed <= 1'b0;
    else
      popArmed <= psel && !penable && !pwrite && (paddr == acq_pkg::DATA_OFS)
                  && (bufCnt != 2'h0);
  end

  always_ff @(posedge clk)
  begin
    if (bufPush)
      bufMem[bufWr] <= link.wordData;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || fifoReset)
    begin
      bufWr  <= 1'b0;
      bufRd  <= 1'b0;
      bufCnt <= 2'h0;
    end
    else
    begin
      if (bufPush)
        bufWr <= !bufWr;
      if (bufPop)
        bufRd <= !bufRd;
      bufCnt <= bufCnt + 2'(bufPush) - 2'(bufPop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        acq_pkg::CTRL_OFS:   prdata <= acq_pkg::WORD_W'(ctrl);
        acq_pkg::NUMCH_OFS:  prdata <= acq_pkg::WORD_W'(numChan);
        acq_pkg::DECIM_OFS:  prdata <= acq_pkg::WORD_W'(decim);
        acq_pkg::CLKWD_OFS:  prdata <= clkWord;
        acq_pkg::STATUS_OFS: prdata <= acq_pkg::WORD_W'({link.fifoEmpty, link.halfFull,
                                                          link.acqActive, bufCnt != 2'h0});
        acq_pkg::DATA_OFS:   prdata <= (bufCnt != 2'h0) ? bufMem[bufRd] : '0;
        default:             prdata <= '0;
      endcase
    end
  end
endmodule : acq_host

// ---- acq_link_if.sv ----
interface acq_link_if;
  logic                          sampleTick;
  logic                          swAcquire;
  logic                          extSource;
  logic                          packWords;
  logic                          ratio128;
  logic                          fifoReset;
  logic [acq_pkg::CH_W-1:0]      numChan;
  logic [acq_pkg::DEC_W-1:0]     decim;
  logic                          wordValid;
  logic [acq_pkg::WORD_W-1:0]    wordData;
  logic                          wordReady;
  logic                          acqActive;
  logic                          halfFull;
  logic                          fifoEmpty;

  modport device (
    input  sampleTick, swAcquire, extSource, packWords, ratio128, fifoReset,
    input  numChan, decim, wordReady,
    output wordValid, wordData, acqActive, halfFull, fifoEmpty
  );

  modport host (
    output sampleTick, swAcquire, extSource, packWords, ratio128, fifoReset,
    output numChan, decim, wordReady,
    input  wordValid, wordData, acqActive, halfFull, fifoEmpty
  );
endinterface : acq_link_if

// ---- acq_pkg.sv ----
package acq_pkg;
  localparam int SAMPLE_W      = 24;
  localparam int WORD_W        = 32;
  localparam int HALF_W        = 16;
  localparam int PAD_W         = WORD_W - SAMPLE_W;
  localparam int MAX_CH        = 32;
  localparam int CH_W          = 6;
  localparam int SEL_W         = 5;
  localparam int DEC_W         = 5;
  localparam int DECIM_MAX     = 16;
  localparam int TICKS_PER_MOD = 4;
  localparam int ADDR_W        = 8;

  localparam logic [7:0] MOD_PER_FRAME_64  = 8'h40;
  localparam logic [7:0] MOD_PER_FRAME_128 = 8'h80;

  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] NUMCH_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] DECIM_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] CLKWD_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] DATA_OFS   = 8'h14;

  localparam int CTRL_ACQ    = 0;
  localparam int CTRL_EXTSRC = 1;
  localparam int CTRL_PACK   = 2;
  localparam int CTRL_RATIO  = 3;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_EXTCLK = 5;
  localparam int CTRL_FRST   = 6;
  localparam int CTRL_W      = 6;

  localparam int ST_BUFDATA = 0;
  localparam int ST_ACTIVE  = 1;
  localparam int ST_HALF    = 2;
  localparam int ST_EMPTY   = 3;

  localparam logic [CTRL_W-1:0] CTRL_RESET  = 6'h00;
  localparam logic [CH_W-1:0]   NUMCH_RESET = 6'h02;
  localparam logic [DEC_W-1:0]  DECIM_RESET = 5'h01;
  localparam logic [WORD_W-1:0] CLKWD_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    G_IDLE  = 2'b00,
    G_LATCH = 2'b01,
    G_READ  = 2'b10
  } gather_t;

  typedef enum logic {
    O_ODD  = 1'b0,
    O_EVEN = 1'b1
  } outsel_t;

  function automatic logic [CH_W-1:0] evenChannels(input logic [WORD_W-1:0] v);
    if (v > WORD_W'(MAX_CH))
      return CH_W'(MAX_CH);
    return {v[CH_W-1:1], 1'b0};
  endfunction : evenChannels

  function automatic logic [DEC_W-1:0] decimFactor(input logic [WORD_W-1:0] v);
    if (v == '0)
      return DEC_W'(1);
    if (v > WORD_W'(DECIM_MAX))
      return DEC_W'(DECIM_MAX);
    return v[DEC_W-1:0];
  endfunction : decimFactor
endpackage : acq_pkg

// ---- acq_properties.sv ----
module acq_properties (
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire logic                       swAcquire,
  input wire logic                       extSource,
  input wire logic                       fifoReset,
  input wire logic [acq_pkg::CH_W-1:0]   numChan,
  input wire logic [acq_pkg::DEC_W-1:0]  decim,
  input wire logic                       wordValid,
  input wire logic [acq_pkg::WORD_W-1:0] wordData,
  input wire logic                       wordReady,
  input wire logic                       acqActive,
  input wire logic                       halfFull,
  input wire logic                       fifoEmpty
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // a stalled word must wait whole, or the receiver loses it
  sequence stalled;
    wordValid && !wordReady && !fifoReset;
  endsequence
  sequence heldOver;
    wordValid && $stable(wordData);
  endsequence
  sequence cleared;
    fifoEmpty && !halfFull;
  endsequence

  AST_WORD_HOLD:
    assert property (stalled |=> heldOver) else $error("word changed while stalled");
  AST_NUMCH_EVEN:
    assert property (numChan[0] == 1'h0 && numChan <= 6'h20) else $error("bad channel count");
  AST_DECIM_RANGE:
    assert property (decim != 5'h00 && decim <= 5'h10) else $error("bad decimation factor");
  AST_HALF_NOT_EMPTY:
    assert property (halfFull |-> !fifoEmpty) else $error("half full while empty");
  AST_HALF_RISE:
    assert property ($rose(halfFull) |-> !$past(fifoEmpty)) else $error("half full from empty");
  AST_FIFO_CLEAR:
    assert property (fifoReset |-> ##[1:3] cleared) else $error("buffers not cleared");
  AST_WORD_CLEAR:
    assert property (fifoReset |-> ##[1:2] !wordValid) else $error("word kept after clear");
  AST_ACTIVE_SOURCE:
    assert property ($rose(acqActive) |-> (swAcquire || extSource))
      else $error("acquisition without a gate source");
endmodule : acq_properties

// ---- tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LIMIT = 60000;
  logic                         clk;
  logic                         rstn;
  logic [acq_pkg::ADDR_W-1:0]   paddr;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         extClockPin;
  logic                         clusterTrigger;
  logic                         frameStrobe;
  logic [acq_pkg::SEL_W-1:0]    chanSel;
  logic [acq_pkg::SAMPLE_W-1:0] chanData;
  logic                         gate;
  logic                         turn;
  logic [31:0]                  fpData;
  logic                         fpValid;
  logic                         fpOe;
  logic [7:0]                   frameNo = 8'h00;
  logic [31:0]                  rdv;
  logic                         errv;
  logic [31:0]                  wq[$];
  logic [31:0]                  fpQ[$];
  int                           errors = 0;
  int                           checked = 0;
  int                           cycles = 0;

  acq_link_if link ();
  acq_host i_acq_host (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extClockPin(extClockPin), .sampleClkOut(extClockPin),
    .clusterTrigger(clusterTrigger), .link(link));
  acq_device #(.DEPTH(8)) i_acq_device (.clk(clk), .rstn(rstn), .link(link),
    .frameStrobe(frameStrobe), .chanSel(chanSel), .chanData(chanData),
    .externalAcquireGate(gate), .fpTurnPin(turn), .fpData(fpData), .fpValid(fpValid),
    .fpOe(fpOe));
  acq_properties i_acq_properties (.clk(clk), .rstn(rstn), .swAcquire(link.swAcquire),
    .extSource(link.extSource), .fifoReset(link.fifoReset), .numChan(link.numChan),
    .decim(link.decim), .wordValid(link.wordValid), .wordData(link.wordData),
    .wordReady(link.wordReady), .acqActive(link.acqActive), .halfFull(link.halfFull),
    .fifoEmpty(link.fifoEmpty));

  // channel and frame number ride in the sample; low byte is lost when packed
  assign chanData = {3'h0, chanSel, frameNo, 8'h3C};

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (frameStrobe === 1'h1)
      frameNo <= frameNo + 8'h01;
    if (fpValid === 1'h1)
      fpQ.push_back(fpData);
    if (cycles == LIMIT)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic collect(input int n);
    int t0;
    t0 = cycles;
    while (cycles - t0 < n)
    begin
      apb(1'h0, acq_pkg::STATUS_OFS, 32'h0);
      if (rdv[acq_pkg::ST_BUFDATA] === 1'h1)
      begin
        apb(1'h0, acq_pkg::DATA_OFS, 32'h0);
        wq.push_back(rdv);
      end
    end
  endtask : collect

  // clearing first keeps leftovers of the previous mode out of the stream
  task automatic setup(input logic [31:0] nc, input logic [31:0] dec);
    apb(1'h1, acq_pkg::CTRL_OFS, 32'h40);
    apb(1'h1, acq_pkg::NUMCH_OFS, nc);
    apb(1'h1, acq_pkg::DECIM_OFS, dec);
    wq.delete();
    fpQ.delete();
  endtask : setup

  task automatic run(input logic [31:0] ctrl, input int nc, input int dec, input int n);
    setup(nc, dec);
    apb(1'h1, acq_pkg::CTRL_OFS, ctrl);
    chk("cluster trigger", 32'(ctrl[4]), 32'(clusterTrigger));
    collect(n);
    apb(1'h1, acq_pkg::CTRL_OFS, ctrl & 32'hFFFFFFFE);
    collect(1600);
  endtask : run

  task automatic check_stream(input logic [31:0] w[$], input int nc, input logic pk);
    int          per;
    logic [7:0]  fn;
    logic [31:0] e;
    per = pk ? nc / 2 : nc;
    chk("whole frames", 32'h1, 32'(w.size() > 0 && w.size() % per == 0));
    for (int i = 0; i < w.size(); i++)
    begin
      // frameNo counts latched frames only, so discarded ones leave no gap
      fn = w[0][23:16] + 8'(i / per);
      if (pk)
        e = {3'h0, 5'(2 * (i % per)), fn, 3'h0, 5'(2 * (i % per) + 1), fn};
      else
        e = {3'h0, 5'(i % per), fn, 8'h3C, 8'h00};
      chk("data word", e, w[i]);
    end
  endtask : check_stream

  task automatic reg_values;
    logic [7:0]  ra[6];
    logic [31:0] wv[6];
    logic [31:0] ev[6];
    ra = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h0C};
    wv = '{32'h0, 32'h7, 32'h28, 32'h0, 32'h14, 32'h80000000};
    ev = '{32'h0, 32'h6, 32'h20, 32'h1, 32'h10, 32'h80000000};
    apb(1'h0, acq_pkg::NUMCH_OFS, 32'h0);
    chk("channel count reset", 32'(acq_pkg::NUMCH_RESET), rdv);
    apb(1'h0, acq_pkg::DECIM_OFS, 32'h0);
    chk("decimation reset", 32'(acq_pkg::DECIM_RESET), rdv);
    apb(1'h0, acq_pkg::STATUS_OFS, 32'h0);
    chk("status reset", 32'h8, rdv);
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, 32'(errv));
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h1, ra[i], wv[i]);
      apb(1'h0, ra[i], 32'h0);
      chk("register value", ev[i], rdv);
    end
  endtask : reg_values

  task automatic full_run;
    turn <= 1'h1;
    run(32'h31, 4, 1, 3000);
    check_stream(wq, 4, 1'h0);
    check_stream(fpQ, 4, 1'h0);
    chk("front panel enable", 32'h1, 32'(fpOe));
  endtask : full_run

  task automatic packed_run;
    run(32'h05, 4, 1, 3000);
    check_stream(wq, 4, 1'h1);
    check_stream(fpQ, 4, 1'h0);
  endtask : packed_run

  task automatic decim_run;
    turn <= 1'h0;
    run(32'h09, 6, 3, 10000);
    check_stream(wq, 6, 1'h0);
    chk("front panel idle", 32'h0, 32'(fpOe));
    chk("kept frames", 32'h1, 32'((wq.size() / 6) inside {[3:5]}));
    chk("front panel words", 32'h0, 32'(fpQ.size()));
  endtask : decim_run

  task automatic gate_run;
    int n;
    setup(2, 1);
    apb(1'h1, acq_pkg::CTRL_OFS, 32'h03);
    collect(1200);
    chk("words before gate", 32'h0, 32'(wq.size()));
    gate <= 1'h1;
    collect(1500);
    gate <= 1'h0;
    collect(1600);
    n = wq.size();
    collect(1200);
    chk("words after gate", 32'(n), 32'(wq.size()));
    check_stream(wq, 2, 1'h0);
  endtask : gate_run

  task automatic half_run;
    setup(4, 1);
    apb(1'h1, acq_pkg::CTRL_OFS, 32'h01);
    repeat (3000) @(posedge clk);
    apb(1'h0, acq_pkg::STATUS_OFS, 32'h0);
    chk("half full and active", 32'h6, rdv & 32'h6);
    apb(1'h1, acq_pkg::CTRL_OFS, 32'h0);
    repeat (1100) @(posedge clk);
    apb(1'h1, acq_pkg::CTRL_OFS, 32'h40);
    repeat (4) @(posedge clk);
    apb(1'h0, acq_pkg::STATUS_OFS, 32'h0);
    chk("status after clear", 32'h8, rdv);
    apb(1'h0, acq_pkg::DATA_OFS, 32'h0);
    chk("data when empty", 32'h0, rdv);
  endtask : half_run

  initial
  begin
    rstn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gate = 1'h0;
    turn = 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    reg_values();
    full_run();
    packed_run();
    decim_run();
    gate_run();
    half_run();
    complete_run();
  end
endmodule : tb
